// ==== design/smac_core.sv ====
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module smac_core
    import smac_pkg::*;
#(
    parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic SMB_SCL,
    output logic SDA_RELEASE,
    input wire logic ADDR_ENABLE_STRAP,
    input wire logic ADDR_SELECT_STRAP,
    input wire logic [5:0] CPU_VOLTAGE_CODE_INPUTS,
    output logic VOLTAGE_CODE_THRESHOLD_SEL,
    output logic ADC_START,
    output logic [3:0] ADC_CHAN,
    input wire logic ADC_DONE,
    input wire logic [7:0] ADC_DATA,
    output logic ALERT_A_N,
    output logic ALERT_B_N
);
    localparam logic [TO_CNT_W-1:0] TO_LAST = TO_CNT_W'(TIMEOUT_CYC - 1);

    smac_mem_if mif();

    smac_regmem u_mem (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .mif(mif.mem)
    );

    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic aw_got_r, w_got_r, w_lane_r, rd_wait_r, rd_fin_r;
    logic [3:0] aw_addr_r, ar_addr_r;
    logic [7:0] w_data_r, ptr_r, cfg_r;
    logic [ST_W-1:0] status_r, mask_r, st_set, st_clr;
    logic [5:0] vid_r;
    logic vid_valid_r, sel_r, lock_r, release_r;
    logic [6:0] act_addr_r;
    logic [TO_CNT_W-1:0] scl_cnt_r;
    smac_state_t st_r;
    logic [3:0] ch_r;
    logic [7:0] val_r, lo_r;
    logic adc_start_r, alert_a_n_r, alert_b_n_r, voltage_code_threshold_sel_r;

    //****************************************
    // decode
    //****************************************
    wire wr_do = aw_got_r & w_got_r & ~bvalid_r & ~mif.busy;
    wire aw_is_abyte = (aw_addr_r == AXI_ADDR_BYTE);
    wire aw_is_ptr = (aw_addr_r == AXI_POINTER) & sel_r;
    wire aw_is_data = (aw_addr_r == AXI_DATA) & sel_r;
    wire wr_ok = aw_is_abyte | aw_is_ptr | aw_is_data;
    wire wr_eff = wr_do & w_lane_r;
    wire wr_abyte = wr_eff & aw_is_abyte;
    wire wr_ptr = wr_eff & aw_is_ptr;
    wire wr_data = wr_eff & aw_is_data;
    wire abyte_match = (w_data_r[7:1] == act_addr_r);

    wire p_cfg = (ptr_r == PTR_CFG);
    wire p_stlo = (ptr_r == PTR_STATUS_LO);
    wire p_sthi = (ptr_r == PTR_STATUS_HI);
    wire p_vid = (ptr_r == PTR_VID);
    wire p_mklo = (ptr_r == PTR_MASK_LO);
    wire p_mkhi = (ptr_r == PTR_MASK_HI);
    wire p_flop = p_cfg | p_stlo | p_sthi | p_vid | p_mklo | p_mkhi;
    // limits, offsets and fan start temperatures live in memory
    wire mem_sw_we = wr_data & ~p_flop;

    wire [7:0] ptr_rd = p_cfg ? cfg_r :
                        p_stlo ? status_r[7:0] :
                        p_sthi ? status_r[15:8] :
                        p_vid ? {2'b00, vid_r} :
                        p_mklo ? mask_r[7:0] :
                        p_mkhi ? mask_r[15:8] : mif.a_data;
    wire ar_is_abyte = (ar_addr_r == AXI_ADDR_BYTE);
    wire ar_is_ptr = (ar_addr_r == AXI_POINTER) & sel_r;
    wire ar_is_data = (ar_addr_r == AXI_DATA) & sel_r;
    wire rd_ok = ar_is_abyte | ar_is_ptr | ar_is_data;
    wire [7:0] rd_byte = ar_is_abyte ? {lock_r, act_addr_r} :
                         ar_is_ptr ? ptr_r :
                         ar_is_data ? ptr_rd : 8'h00;
    wire rd_clr_lo = rd_fin_r & ar_is_data & p_stlo;
    wire rd_clr_hi = rd_fin_r & ar_is_data & p_sthi;

    wire is_temp = (ch_r >= CH_LOCAL_TEMP) & (ch_r <= CH_REMOTE_DIODE_TWO);
    wire [7:0] hi_lim = mif.b_data;
    wire below = is_temp ? ($signed(val_r) < $signed(lo_r)) : (val_r < lo_r);
    wire above = is_temp ? ($signed(val_r) > $signed(hi_lim)) : (val_r > hi_lim);
    wire seq_wr = (st_r == S_CMP) & ~mem_sw_we & ~mif.busy;
    wire seq_flag = seq_wr & (below | above);
    wire vid_chg = vid_valid_r & (CPU_VOLTAGE_CODE_INPUTS != vid_r);
    wire alert_any = |(status_r & ~mask_r);
    wire to_fire = ~SMB_SCL & ~cfg_r[CFG_TO_DIS] & ~release_r & (scl_cnt_r == TO_LAST);

    assign mif.we = mem_sw_we | seq_wr;
    assign mif.waddr = mem_sw_we ? ptr_r : PTR_VALUE_BASE + {4'h0, ch_r};
    assign mif.wdata = mem_sw_we ? w_data_r : val_r;
    assign mif.a_addr = ptr_r;
    assign mif.b_addr = (st_r == S_OFS) ? PTR_OFS_BASE + {4'h0, ch_r} :
                        (st_r == S_LO) ? PTR_LOW_BASE + {4'h0, ch_r} :
                        PTR_HIGH_BASE + {4'h0, ch_r};

    genvar gi;
    generate
        for (gi = 0; gi < ST_W; gi++) begin : g_st
            if (gi < NUM_CH) begin : g_ch
                assign st_set[gi] = seq_flag & (ch_r == 4'(gi));
            end else if (gi == ST_VID) begin : g_vid
                assign st_set[gi] = vid_chg;
            end else begin : g_none
                assign st_set[gi] = 1'b0;
            end
            assign st_clr[gi] = (gi < 8) ? rd_clr_lo : rd_clr_hi;
        end
    endgenerate

    //****************************************
    // axi write channel
    //****************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 8'h00;
            w_lane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && awready_r) begin
                aw_got_r <= 1'b1;
                awready_r <= 1'b0;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && wready_r) begin
                w_got_r <= 1'b1;
                wready_r <= 1'b0;
                w_data_r <= S_AXI_WDATA[7:0];
                w_lane_r <= S_AXI_WSTRB[0];
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && S_AXI_BREADY) begin
                bvalid_r <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    //****************************************
    // axi read channel
    //****************************************
    // two wait cycles cover the registered memory read behind the pointer
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            arready_r <= 1'b1;
            ar_addr_r <= 4'h0;
            rd_wait_r <= 1'b0;
            rd_fin_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else begin
            if (S_AXI_ARVALID && arready_r) begin
                arready_r <= 1'b0;
                ar_addr_r <= S_AXI_ARADDR;
                rd_wait_r <= 1'b1;
            end
            if (rd_wait_r) begin
                rd_wait_r <= 1'b0;
                rd_fin_r <= 1'b1;
            end
            if (rd_fin_r) begin
                rd_fin_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= {24'h00_0000, rd_byte};
                rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid_r && S_AXI_RREADY) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    //****************************************
    // pointer, configuration, mask, status
    //****************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ptr_r <= 8'h00;
            cfg_r <= CFG_RESET;
            mask_r <= MASK_RESET;
            status_r <= '0;
        end else begin
            if (wr_ptr) begin
                ptr_r <= w_data_r;
            end
            if (wr_data && p_cfg) begin
                cfg_r <= w_data_r;
            end
            if (wr_data && p_mklo) begin
                mask_r[7:0] <= w_data_r;
            end
            if (wr_data && p_mkhi) begin
                mask_r[15:8] <= w_data_r;
            end
            // set wins over read-clear in the same cycle
            status_r <= st_set | (status_r & ~st_clr);
        end
    end

    //****************************************
    // slave address and clock-low timeout
    //****************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            act_addr_r <= SLAVE_ADDR_DEFAULT;
            lock_r <= 1'b0;
            sel_r <= 1'b0;
            scl_cnt_r <= '0;
            release_r <= 1'b0;
        end else begin
            if (!lock_r) begin
                act_addr_r <= ADDR_ENABLE_STRAP ? SLAVE_ADDR_DEFAULT :
                              (ADDR_SELECT_STRAP ? SLAVE_ADDR_SEL_HIGH : SLAVE_ADDR_SEL_LOW);
            end
            if (wr_abyte) begin
                sel_r <= abyte_match;
                lock_r <= lock_r | abyte_match;
            end
            if (SMB_SCL || cfg_r[CFG_TO_DIS]) begin
                scl_cnt_r <= '0;
                release_r <= 1'b0;
            end else if (to_fire) begin
                release_r <= 1'b1;
            end else if (!release_r) begin
                scl_cnt_r <= scl_cnt_r + 1'b1;
            end
            if (to_fire) begin
                sel_r <= 1'b0;
            end
        end
    end

    //****************************************
    // voltage code and pin outputs
    //****************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            vid_r <= 6'h00;
            vid_valid_r <= 1'b0;
            alert_a_n_r <= 1'b1;
            alert_b_n_r <= 1'b1;
            voltage_code_threshold_sel_r <= 1'b0;
        end else begin
            vid_r <= CPU_VOLTAGE_CODE_INPUTS;
            vid_valid_r <= 1'b1;
            // pins not set up for alert stay released
            alert_a_n_r <= ~(cfg_r[CFG_ALERT_A] & alert_any);
            alert_b_n_r <= ~(cfg_r[CFG_ALERT_B] & alert_any);
            voltage_code_threshold_sel_r <= cfg_r[CFG_VID_VOLTAGE_CODE_THRESHOLD_SEL];
        end
    end

    //****************************************
    // measurement sequencer
    //****************************************
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= S_IDLE;
            ch_r <= CH_FIRST;
            val_r <= 8'h00;
            lo_r <= 8'h00;
            adc_start_r <= 1'b0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (cfg_r[CFG_START] && !mif.busy) begin
                        adc_start_r <= 1'b1;
                        st_r <= S_CONV;
                    end
                end
                S_CONV: begin
                    adc_start_r <= 1'b0;
                    if (ADC_DONE) begin
                        val_r <= ADC_DATA;
                        st_r <= S_OFS;
                    end
                end
                S_OFS: begin
                    st_r <= S_LO;
                end
                S_LO: begin
                    if (is_temp) begin
                        val_r <= val_r + mif.b_data;
                    end
                    st_r <= S_HI;
                end
                S_HI: begin
                    lo_r <= mif.b_data;
                    st_r <= S_CMP;
                end
                S_CMP: begin
                    // software memory writes take priority; a stall holds here
                    if (seq_wr) begin
                        ch_r <= (ch_r == CH_LAST) ? CH_FIRST : ch_r + CH_STEP;
                        st_r <= S_IDLE;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    assign SDA_RELEASE = release_r;
    assign VOLTAGE_CODE_THRESHOLD_SEL = voltage_code_threshold_sel_r;
    assign ADC_START = adc_start_r;
    assign ADC_CHAN = ch_r;
    assign ALERT_A_N = alert_a_n_r;
    assign ALERT_B_N = alert_b_n_r;

    //****************************************
    // assertions
    //****************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence limit_reads_s;
        st_r == S_OFS ##1 st_r == S_LO ##1 st_r == S_HI ##1 st_r == S_CMP;
    endsequence

    conv_walk_a: assert property (st_r == S_CONV && ADC_DONE |=> limit_reads_s)
        else $error("limit reads out of order");
    chan_wrap_a: assert property (seq_wr && ch_r == CH_LAST |=> ch_r == CH_FIRST && st_r == S_IDLE)
        else $error("channel did not wrap");
    flag_set_a: assert property (seq_flag |=> status_r[$past(ch_r)])
        else $error("out-of-limit flag missing");
    temp_offset_a: assert property (st_r == S_LO && is_temp |=> val_r == 8'($past(val_r) + $past(mif.b_data)))
        else $error("offset not applied");
    vid_flag_a: assert property (vid_chg |=> status_r[ST_VID])
        else $error("code change not flagged");
    alert_drive_a: assert property (alert_any && cfg_r[CFG_ALERT_A] |=> !ALERT_A_N)
        else $error("alert not driven");
    mask_block_a: assert property (!alert_any |=> ALERT_A_N && ALERT_B_N)
        else $error("masked flag drove alert");
    flag_sticky_a: assert property (status_r[ST_VID] && !st_clr[ST_VID] |=> status_r[ST_VID])
        else $error("flag dropped before read");
    addr_default_a: assert property (!lock_r && ADDR_ENABLE_STRAP |=> act_addr_r == SLAVE_ADDR_DEFAULT)
        else $error("default address wrong");
    addr_select_a: assert property (!lock_r && !ADDR_ENABLE_STRAP |=>
        act_addr_r == ($past(ADDR_SELECT_STRAP) ? SLAVE_ADDR_SEL_HIGH : SLAVE_ADDR_SEL_LOW))
        else $error("selected address wrong");
    addr_lock_a: assert property (lock_r |=> lock_r && $stable(act_addr_r))
        else $error("address changed after lock");
    ptr_load_a: assert property (wr_ptr |=> ptr_r == $past(w_data_r))
        else $error("pointer not loaded");
    bus_release_a: assert property (to_fire |=> SDA_RELEASE && !sel_r)
        else $error("timeout did not release");
endmodule // smac_core

// ==== design/smac_mem_if.sv ====
`timescale 1ns/1ps
interface smac_mem_if;
    logic we;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic [7:0] a_addr;
    logic [7:0] a_data;
    logic [7:0] b_addr;
    logic [7:0] b_data;
    logic busy;
    modport ctl (output we, output waddr, output wdata, output a_addr, output b_addr,
                 input a_data, input b_data, input busy);
    modport mem (input we, input waddr, input wdata, input a_addr, input b_addr,
                 output a_data, output b_data, output busy);
endinterface

// ==== design/smac_pkg.sv ====
package smac_pkg;
    // axi byte offsets
    localparam logic [3:0] AXI_ADDR_BYTE = 4'h0;
    localparam logic [3:0] AXI_POINTER = 4'h4;
    localparam logic [3:0] AXI_DATA = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // slave addresses
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2E;
    localparam logic [6:0] SLAVE_ADDR_SEL_LOW = 7'h2C;
    localparam logic [6:0] SLAVE_ADDR_SEL_HIGH = 7'h2D;

    // measurement channels
    localparam int NUM_VOLT_IN = 4;
    localparam int NUM_REMOTE_TEMP = 2;
    localparam int NUM_CH = 10;
    localparam logic [3:0] CH_FIRST = 4'h0;
    localparam logic [3:0] CH_STEP = 4'h1;
    localparam logic [3:0] CH_VCC = 4'h4;
    localparam logic [3:0] CH_LOCAL_TEMP = 4'h5;
    localparam logic [3:0] CH_REMOTE_DIODE_ONE = 4'h6;
    localparam logic [3:0] CH_REMOTE_DIODE_TWO = 4'h7;
    localparam logic [3:0] CH_FAN_ONE = 4'h8;
    localparam logic [3:0] CH_LAST = 4'h9;

    // internal register space behind the pointer
    localparam logic [7:0] PTR_VALUE_BASE = 8'h20;
    localparam logic [7:0] PTR_CFG = 8'h40;
    localparam logic [7:0] PTR_STATUS_LO = 8'h41;
    localparam logic [7:0] PTR_STATUS_HI = 8'h42;
    localparam logic [7:0] PTR_VID = 8'h43;
    localparam logic [7:0] PTR_MASK_LO = 8'h44;
    localparam logic [7:0] PTR_MASK_HI = 8'h45;
    localparam logic [7:0] PTR_LOW_BASE = 8'h50;
    localparam logic [7:0] PTR_HIGH_BASE = 8'h60;
    localparam logic [7:0] PTR_OFS_BASE = 8'h70;
    localparam logic [7:0] PTR_FAN_START_BASE = 8'h80;

    // configuration bits
    localparam int CFG_START = 0;
    localparam int CFG_TO_DIS = 1;
    localparam int CFG_ALERT_A = 2;
    localparam int CFG_ALERT_B = 3;
    localparam int CFG_VID_VOLTAGE_CODE_THRESHOLD_SEL = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] MASK_RESET = 16'h0000;

    // status layout
    localparam int ST_W = 16;
    localparam int ST_VID = 10;

    // clock-low timeout
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int TIMEOUT_MIN_MS = 15;
    localparam int TIMEOUT_MAX_MS = 35;
    localparam int MS_PER_S = 1000;
    localparam int TIMEOUT_CYC_DEF = TIMEOUT_MIN_MS * (CORE_CLK_HZ / MS_PER_S);
    localparam int TO_CNT_W = 18;

    // register memory
    localparam int MEM_DEPTH = 256;
    localparam logic [7:0] MEM_LAST = 8'hFF;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CONV = 3'h1,
        S_OFS = 3'h3,
        S_LO = 3'h2,
        S_HI = 3'h6,
        S_CMP = 3'h7
    } smac_state_t;
endpackage

// ==== design/smac_regmem.sv ====
`timescale 1ns/1ps
module smac_regmem
    import smac_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    smac_mem_if.mem mif
);
    logic [7:0] mem_q [0:MEM_DEPTH-1];
    logic [7:0] clr_r;
    logic busy_r;
    logic [7:0] a_r;
    logic [7:0] b_r;

    // sweep to zero after reset so limits and offsets start defined
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_r <= 8'h00;
            busy_r <= 1'b1;
            a_r <= 8'h00;
            b_r <= 8'h00;
        end else begin
            if (busy_r) begin
                clr_r <= clr_r + 8'h01;
                busy_r <= (clr_r != MEM_LAST);
            end
            a_r <= mem_q[mif.a_addr];
            b_r <= mem_q[mif.b_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (busy_r) begin
            mem_q[clr_r] <= 8'h00;
        end else if (mif.we) begin
            mem_q[mif.waddr] <= mif.wdata;
        end
    end

    assign mif.a_data = a_r;
    assign mif.b_data = b_r;
    assign mif.busy = busy_r;
endmodule // smac_regmem

// ==== sim/smac_adc_model.sv ====
`timescale 1ns/1ps
module smac_adc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [3:0] chan,
    output logic done,
    output logic [7:0] data
);
    int cnt;
    logic [3:0] ch_r;
    // odd channels answer slowly; data toggles outside done so stale values never pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            done <= 1'b0;
            data <= 8'h00;
            ch_r <= 4'h0;
        end else begin
            done <= 1'b0;
            data <= ~data;
            if (start) begin
                cnt <= chan[0] ? 6 : 1;
                ch_r <= chan;
            end else if (cnt == 1) begin
                done <= 1'b1;
                data <= 8'h10 + {4'h0, ch_r};
                cnt <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // smac_adc_model

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import smac_pkg::*;
    localparam int TO = 20;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, scl = 1, aen = 1, asel = 0;
    logic [3:0] awa = 0, ara = 0, ch;
    logic [31:0] wd = 0, rd_d;
    logic [5:0] code = 0;
    logic awr, wr, bv, arr, rv, rel, thr, st, dn, al_a, al_b;
    logic [1:0] br, rr;
    logic [7:0] ad;
    logic [7:0] pt [3];
    logic [7:0] mdl [int];
    int n_mismatch = 0, check_count = 0, seed = 10772, n;
    initial forever #50 clk = ~clk;
    smac_core #(.TIMEOUT_CYC(TO)) smac_core_i (.CORE_CLK(clk), .NRST(rst_n), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'h1), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd_d),
        .S_AXI_RRESP(rr), .SMB_SCL(scl), .SDA_RELEASE(rel), .ADDR_ENABLE_STRAP(aen), .ADDR_SELECT_STRAP(asel),
        .CPU_VOLTAGE_CODE_INPUTS(code), .VOLTAGE_CODE_THRESHOLD_SEL(thr), .ADC_START(st), .ADC_CHAN(ch),
        .ADC_DONE(dn), .ADC_DATA(ad), .ALERT_A_N(al_a), .ALERT_B_N(al_b));
    smac_adc_model smac_adc_model_i (.clk(clk), .rst_n(rst_n), .start(st), .chan(ch), .done(dn), .data(ad));
    // ****************
    // bus tasks
    // ****************
    task automatic end_of_test;
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic lim();
        if (n >= 1000) begin
            n_mismatch++;
            $display("ERROR %0t: wait limit", $time);
            end_of_test();
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= {24'h0000_00, d};
        bry <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            n++;
        end while (bv !== 1'b1 && n < 1000);
        lim();
        chk({30'h0, br}, {30'h0, er});
        bry <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            n++;
        end while (rv !== 1'b1 && n < 1000);
        lim();
        chk(rd_d & m, exp);
        chk({30'h0, rr}, {30'h0, er});
        rry <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] p, input logic [7:0] d);
        axw(AXI_POINTER, p, RESP_OKAY);
        axw(AXI_DATA, d, RESP_OKAY);
        mdl[p] = d;
    endtask
    task automatic rreg(input logic [7:0] p, input logic [7:0] m);
        axw(AXI_POINTER, p, RESP_OKAY);
        axr(AXI_DATA, {24'h0000_00, mdl[p] & m}, {24'h0000_00, m}, RESP_OKAY);
    endtask
    // ****************
    // scenarios
    // ****************
    initial begin
        pt = '{PTR_FAN_START_BASE, PTR_FAN_START_BASE + 8'h01, 8'h90};
        repeat (10) @(posedge clk);
        chk({28'h0, al_a, al_b, rel, awr}, 32'h0000_000D);
        rst_n <= 1'b1;
        axr(AXI_ADDR_BYTE, {25'h0, SLAVE_ADDR_DEFAULT}, 32'hFF, RESP_OKAY);
        aen <= 1'b0;
        asel <= 1'b1;
        axr(AXI_ADDR_BYTE, {25'h0, SLAVE_ADDR_SEL_HIGH}, 32'hFF, RESP_OKAY);
        asel <= 1'b0;
        axr(AXI_ADDR_BYTE, {25'h0, SLAVE_ADDR_SEL_LOW}, 32'hFF, RESP_OKAY);
        axw(AXI_POINTER, PTR_CFG, RESP_SLVERR);
        axr(4'hC, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        axw(AXI_ADDR_BYTE, {SLAVE_ADDR_SEL_LOW, 1'b0}, RESP_OKAY);
        asel <= 1'b1;
        axr(AXI_ADDR_BYTE, {24'h0, 1'b1, SLAVE_ADDR_SEL_LOW}, 32'hFF, RESP_OKAY);
        foreach (pt[i]) begin
            wreg(pt[i], 8'($random(seed)));
            rreg(pt[i], 8'hFF);
        end
        axr(AXI_POINTER, 32'h90, 32'hFF, RESP_OKAY);
        // forced odd so the code always differs from its reset value
        code <= 6'($random(seed)) | 6'h01;
        @(posedge clk);
        mdl[PTR_VID] = {2'b00, code};
        rreg(PTR_VID, 8'h3F);
        // clear the change flag now, or it would hold the alert low below
        mdl[PTR_STATUS_HI] = 8'h04;
        rreg(PTR_STATUS_HI, 8'h07);
        wreg(PTR_CFG, 8'h40);
        @(posedge clk);
        chk({31'h0, thr}, 32'h1);
        // limits chosen so only channel 0 goes out of range
        for (int c = 0; c < NUM_CH; c++) begin
            wreg(PTR_HIGH_BASE + 8'(c), c == 0 ? 8'h05 : (c >= 5 && c <= 7) ? 8'h7F : 8'hFF);
            mdl[PTR_VALUE_BASE + c] = 8'h10 + 8'(c) + (c == 5 ? 8'hFE : 8'h00);
        end
        wreg(PTR_OFS_BASE + 8'h05, 8'hFE);
        wreg(PTR_MASK_LO, 8'h01);
        wreg(PTR_CFG, 8'h05);
        n = 0;
        for (int k = 0; k < 11 && n < 1000; n++) begin
            @(posedge clk);
            if (st) k++;
        end
        lim();
        chk({30'h0, al_a, al_b}, 32'h3);
        wreg(PTR_MASK_LO, 8'h00);
        repeat (4) @(posedge clk);
        chk({31'h0, al_a}, 32'h0);
        wreg(PTR_CFG, 8'h09);
        repeat (4) @(posedge clk);
        chk({30'h0, al_a, al_b}, 32'h2);
        mdl[PTR_STATUS_LO] = 8'h01;
        rreg(PTR_STATUS_LO, 8'hFF);
        wreg(PTR_CFG, 8'h08);
        repeat (200) @(posedge clk);
        rreg(PTR_STATUS_LO, 8'hFE);
        mdl[PTR_STATUS_LO] = 8'h00;
        rreg(PTR_STATUS_LO, 8'hFF);
        chk({31'h0, al_b}, 32'h1);
        for (int c = 0; c < NUM_CH; c++) rreg(PTR_VALUE_BASE + 8'(c), 8'hFF);
        code <= ~code;
        mdl[PTR_STATUS_HI] = 8'h04;
        rreg(PTR_STATUS_HI, 8'h07);
        mdl[PTR_STATUS_HI] = 8'h00;
        rreg(PTR_STATUS_HI, 8'h07);
        wreg(PTR_CFG, 8'h02);
        scl <= 1'b0;
        repeat (2 * TO) @(posedge clk);
        chk({31'h0, rel}, 32'h0);
        wreg(PTR_CFG, 8'h00);
        repeat (TO + 5) @(posedge clk);
        chk({31'h0, rel}, 32'h1);
        axw(AXI_POINTER, PTR_CFG, RESP_SLVERR);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, rel}, 32'h0);
        end_of_test();
    end
endmodule // tb_top
